// file: reset_strap_pin_function_mux_bench.sv
// Self-checking bench for the pin multiplexer with its board model
`timescale 1ns/1ns
`default_nettype none
module reset_strap_pin_function_mux_bench;
    import rspm_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, irq, host_mode, mem_data_oe = 1'b0, mem_byte_access = 1'b0;
    logic        host_ad_oe = 1'b0, host_ack = 1'b0, host_ready = 1'b0;
    logic [7:0]  paddr = 8'h00, pf_pin_in, pf_pin_out, pf_pin_oe, mem_byte_addr_hi = 8'h00;
    logic [7:0]  pf_drive = 8'hff, pf_drive_en = 8'hff;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [2:0]  output_only_flags;
    logic [5:0]  int_pending;
    logic [3:0]  strap_value;
    logic [4:0]  sp1_pin_in = 5'h1f, sp1_core_out = 5'h0, sp1_core_oe = 5'h0;
    logic [4:0]  sp1_pin_out, sp1_pin_oe;
    logic [13:0] addr_pin_out, addr_pin_oe, mem_addr = 14'h0;
    logic [23:0] data_pin_in, data_pin_out, data_pin_oe, mem_wdata = 24'h0, mem_rdata, mem_word;
    logic [15:0] host_ad_out = 16'h0;
    logic [23:0] x;
    int          n_mismatch = 0, cmp_count = 0;
    int          m_reg[8];
    int          wmask[8] = '{32'h1f, 32'hff, 32'hff, 0, 0, 32'h3f, 0, 32'h07};

    always #10 clk = ~clk;

    rspm_pin_mux rspm_pin_mux_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .pf_pin_in, .pf_pin_out, .pf_pin_oe,
        .output_only_flags, .int_pending, .host_mode, .strap_value, .sp1_pin_in, .sp1_pin_out,
        .sp1_pin_oe, .sp1_core_out, .sp1_core_oe, .sp1_core_in(), .serial_alt_flag_in(),
        .addr_pin_in(addr_pin_out), .addr_pin_out, .addr_pin_oe, .data_pin_in, .data_pin_out,
        .data_pin_oe, .mem_addr, .mem_wdata, .mem_data_oe, .mem_byte_access, .mem_byte_addr_hi,
        .mem_rdata, .host_ad_out, .host_ad_oe, .host_ad_in(), .host_wr_n(), .host_rd_n(),
        .host_latch(), .host_sel_n(), .host_ack, .host_ready);
    rspm_board rspm_board_inst (.clk, .pf_pin_out, .pf_pin_oe, .pf_drive, .pf_drive_en,
        .pf_pin_in, .data_pin_out, .data_pin_oe, .mem_word, .mem_drive(1'b1), .data_pin_in);

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Entered just after a rising edge; returns one edge after the release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            $display("FAIL %0t bus answer missing", $time);
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask : rd_chk

    task automatic do_reset(input logic [3:0] s);
        pf_drive[3:0] <= s;
        srst <= 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        m_reg = '{default: 0};
        m_reg[6] = s;
        @(posedge clk);
        pf_drive[3:0] <= ~s;
        repeat (3) @(posedge clk);
    endtask : do_reset

    initial begin
        logic [31:0] v;
        logic        e;
        void'($urandom(281));
        do_reset(4'h9);
        chk(strap_value, 4'h9);
        chk(host_mode, 1'b0);
        for (int i = 0; i < 8; i++) begin
            if (i == 3 || i == 4) continue;
            rd_chk(8'(i * 4), m_reg[i]);
            v = $urandom;
            wr(8'(i * 4), v);
            m_reg[i] = (m_reg[i] & ~wmask[i]) | (v & wmask[i]);
            rd_chk(8'(i * 4), m_reg[i]);
        end
        chk(pf_pin_oe, m_reg[1]);
        chk(pf_pin_out, m_reg[2]);
        chk(output_only_flags, m_reg[7]);
        apb(1'b1, 8'h20, 32'hffffffff, v, e);
        apb(1'b0, 8'h20, 32'h0, v, e);
        chk({v[30:0], e}, 32'h1);
        $display("done: registers and straps");
        wr(ADDR_FLAG_DIR, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_INT_MASK, 32'h3f);
        wr(ADDR_INT_STAT, 32'h3f);
        for (int p = 4; p < 8; p++) begin
            pf_drive[p] <= 1'b0;
            repeat (4) @(posedge clk);
            rd_chk(ADDR_INT_STAT, 1 << (p - 4));
            chk(irq, 1'b1);
            rd_chk(ADDR_FLAG_IN, (~m_reg[6] & 'hf) | ('hf0 & ~(1 << p)));
            wr(ADDR_INT_STAT, 1 << (p - 4));
            rd_chk(ADDR_INT_STAT, (p == 4) ? 0 : 1 << (p - 4));
            pf_drive[p] <= 1'b1;
            repeat (4) @(posedge clk);
            wr(ADDR_INT_STAT, 32'h3f);
        end
        wr(ADDR_FLAG_OUT, 32'h0);
        wr(ADDR_FLAG_DIR, 32'h40);
        repeat (3) @(posedge clk);
        chk(int_pending, 6'h04);
        wr(ADDR_INT_MASK, 32'h0);
        chk({irq, int_pending}, 7'h00);
        wr(ADDR_FLAG_DIR, 32'h0);
        repeat (4) @(posedge clk);
        wr(ADDR_INT_STAT, 32'h3f);
        wr(ADDR_INT_MASK, 32'h3f);
        $display("done: interrupts");
        wr(ADDR_CTRL, 32'h11);
        chk({sp1_pin_oe[3:0], sp1_pin_out[3]}, 5'h11);
        sp1_pin_in[0] <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(ADDR_INT_STAT, 32'h10);
        rd_chk(ADDR_FLAG_IN, 32'h1f6);
        sp1_core_out <= 5'($urandom);
        sp1_core_oe <= 5'($urandom);
        sp1_pin_in[0] <= 1'b1;
        wr(ADDR_CTRL, 32'h0);
        chk({sp1_pin_oe, sp1_pin_out}, {sp1_core_oe, sp1_core_out});
        $display("done: serial port roles");
        repeat (8) begin
            {mem_addr, mem_byte_addr_hi, mem_data_oe, mem_byte_access} <= 24'($urandom);
            {mem_wdata, host_ack} <= 25'($urandom);
            mem_word <= 24'($urandom);
            repeat (3) @(posedge clk);
            x = mem_data_oe ? mem_wdata : mem_word;
            if (mem_byte_access) x[23:16] = mem_byte_addr_hi;
            chk(mem_rdata, x);
            chk(addr_pin_out, mem_addr);
        end
        $display("done: full memory mode");
        do_reset(4'hc);
        chk({host_mode, strap_value}, 5'h1c);
        repeat (6) begin
            {host_ad_out, host_ready, host_ack} <= 18'($urandom);
            repeat (3) @(posedge clk);
            chk(addr_pin_out[13:1], host_ad_out[12:0]);
            chk({data_pin_out[3], data_pin_oe[3]}, {1'b0, host_ready});
            chk(mem_rdata[7:0], 8'h00);
        end
        $display("done: host mode");
        conclude();
    end
endmodule : reset_strap_pin_function_mux_bench
`default_nettype wire

// file: rspm_assertions.sv
// Port-level assertions for the pin multiplexer, bound to its top module
`timescale 1ns/1ns
`default_nettype none
module rspm_assertions (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        irq,
    input wire logic [7:0]  pf_pin_in,
    input wire logic [5:0]  int_pending,
    input wire logic        host_mode,
    input wire logic [3:0]  strap_value,
    input wire logic [13:0] addr_pin_out,
    input wire logic [13:0] addr_pin_oe,
    input wire logic [23:0] data_pin_out,
    input wire logic [23:0] data_pin_oe,
    input wire logic [13:0] mem_addr,
    input wire logic [23:0] mem_wdata,
    input wire logic        mem_data_oe,
    input wire logic        mem_byte_access,
    input wire logic [7:0]  mem_byte_addr_hi,
    input wire logic [15:0] host_ad_out,
    input wire logic        host_ack,
    input wire logic        host_ready
);
    logic [3:0] strap_pins;
    assign strap_pins = pf_pin_in[3:0];
    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    // Two sync stages plus the capture flop sit between pad and strap
    strap_capture_a: assert property ($fell(srst) |-> strap_value == $past(strap_pins, 3))
        else $error("strap value not taken from mode pins");
    strap_hold_a: assert property (!$past(srst) |-> $stable(strap_value))
        else $error("strap value moved outside reset");
    mode_select_a: assert property (host_mode == strap_value[2])
        else $error("operating mode differs from host strap");
    irq_level_a: assert property (irq == (int_pending != 6'h00))
        else $error("interrupt line disagrees with pending sources");
    full_addr_a: assert property (!host_mode |-> addr_pin_out == mem_addr
        && addr_pin_oe == 14'h3fff)
        else $error("address pads not driven from memory address");
    full_data_a: assert property (!host_mode && !mem_byte_access && mem_data_oe
        |-> data_pin_out == mem_wdata && data_pin_oe == 24'hffffff)
        else $error("data pads not driven with write data");
    byte_addr_a: assert property (!host_mode && mem_byte_access
        |-> data_pin_out[23:16] == mem_byte_addr_hi && data_pin_oe[23:16] == 8'hff)
        else $error("upper data pads lack byte address");
    host_addr_a: assert property (host_mode |-> addr_pin_out[13:1] == host_ad_out[12:0])
        else $error("host address lines not on shared pads");
    host_ack_a: assert property (host_mode |-> !data_pin_out[3]
        && data_pin_oe[3] == (strap_value[3] ? host_ready : host_ack))
        else $error("acknowledge pad not open drain as strapped");
endmodule : rspm_assertions

bind rspm_pin_mux rspm_assertions rspm_assertions_inst (
    .clk, .srst, .irq, .pf_pin_in, .int_pending, .host_mode, .strap_value,
    .addr_pin_out, .addr_pin_oe, .data_pin_out, .data_pin_oe, .mem_addr, .mem_wdata,
    .mem_data_oe, .mem_byte_access, .mem_byte_addr_hi, .host_ad_out, .host_ack, .host_ready
);
`default_nettype wire

// file: rspm_board.sv
// Board model: flag and strap lines with pull-ups, memory on the data bus
`timescale 1ns/1ns
`default_nettype none
module rspm_board (
    input wire logic        clk,
    input wire logic [7:0]  pf_pin_out,
    input wire logic [7:0]  pf_pin_oe,
    input wire logic [7:0]  pf_drive,
    input wire logic [7:0]  pf_drive_en,
    output logic     [7:0]  pf_pin_in,
    input wire logic [23:0] data_pin_out,
    input wire logic [23:0] data_pin_oe,
    input wire logic [23:0] mem_word,
    input wire logic        mem_drive,
    output logic     [23:0] data_pin_in
);
    logic [23:0] churn = 24'h000000;

    // Undriven data lines wander so a stale value can never read as valid
    always_ff @(posedge clk) begin
        churn <= churn + 24'h5a5a5b;
    end

    // Board drives the mode straps; released lines float high on pull-ups
    assign pf_pin_in = (pf_pin_oe & pf_pin_out) | (~pf_pin_oe & (~pf_drive_en | pf_drive));
    assign data_pin_in = (data_pin_oe & data_pin_out)
                       | (~data_pin_oe & (mem_drive ? mem_word : churn));
endmodule : rspm_board
`default_nettype wire

// file: rspm_pin_mux.sv
// Pin-function multiplexer with reset-time strapping and APB register file
//
// How it works
// [R1] Bus pin roles fixed at reset; serial port roles changeable by software anytime.
// [R2] Interrupt and flag functions both live on shared pins simultaneously.
// [R3] Four straps sampled only in reset; afterwards those pins are flags.
// [R4] Sampled strap values held unchanged until the next reset.
// [R5] Pin asserted externally or by own flag raises interrupt when enabled.
// [R6] Host strap low selects full memory mode, high host mode; fixed.
// [R7] Each shared pin carries only the strapped mode's signal; other idle. Host mode here leaves address pin 0 and data pins 23:8 on the memory side.
// [R8] Full memory mode drives a 14-bit address bus.
// [R9] 24-bit data bus; upper 8 lines carry byte address on byte access.
// [R10] Edge input edge-triggered, low inputs level, configurable input either.
// [R11] Control register repurposes serial port pins to two interrupts, flag in/out.
// [R12] Host acknowledge is open drain, behaviour chosen by fourth strap.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module rspm_pin_mux (
    input  wire logic                          clk,
    input  wire logic                          srst,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [rspm_pkg::APB_AW-1:0]   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic                               irq,
    // Programmable flag pins, also mode straps and interrupt inputs
    input  wire logic [rspm_pkg::NUM_PF-1:0]   pf_pin_in,
    output logic      [rspm_pkg::NUM_PF-1:0]   pf_pin_out,
    output logic      [rspm_pkg::NUM_PF-1:0]   pf_pin_oe,
    output logic      [rspm_pkg::NUM_OFLAG-1:0] output_only_flags,
    // Interrupt requests towards the sequencer
    output logic      [rspm_pkg::NUM_SRC-1:0]  int_pending,
    output logic                               host_mode,
    output logic      [rspm_pkg::NUM_STRAP-1:0] strap_value,
    // Second serial port: pins and core side
    input  wire logic [rspm_pkg::SP_PINS-1:0]  sp1_pin_in,
    output logic      [rspm_pkg::SP_PINS-1:0]  sp1_pin_out,
    output logic      [rspm_pkg::SP_PINS-1:0]  sp1_pin_oe,
    input  wire logic [rspm_pkg::SP_PINS-1:0]  sp1_core_out,
    input  wire logic [rspm_pkg::SP_PINS-1:0]  sp1_core_oe,
    output logic      [rspm_pkg::SP_PINS-1:0]  sp1_core_in,
    output logic                               serial_alt_flag_in,
    // External address and data pins
    input  wire logic [rspm_pkg::ADDR_W-1:0]   addr_pin_in,
    output logic      [rspm_pkg::ADDR_W-1:0]   addr_pin_out,
    output logic      [rspm_pkg::ADDR_W-1:0]   addr_pin_oe,
    input  wire logic [rspm_pkg::DATA_W-1:0]   data_pin_in,
    output logic      [rspm_pkg::DATA_W-1:0]   data_pin_out,
    output logic      [rspm_pkg::DATA_W-1:0]   data_pin_oe,
    // Memory interface core side
    input  wire logic [rspm_pkg::ADDR_W-1:0]   mem_addr,
    input  wire logic [rspm_pkg::DATA_W-1:0]   mem_wdata,
    input  wire logic                          mem_data_oe,
    input  wire logic                          mem_byte_access,
    input  wire logic [rspm_pkg::BYTE_HI_W-1:0] mem_byte_addr_hi,
    output logic      [rspm_pkg::DATA_W-1:0]   mem_rdata,
    // Host port core side
    input  wire logic [rspm_pkg::HOST_AD_W-1:0] host_ad_out,
    input  wire logic                          host_ad_oe,
    output logic      [rspm_pkg::HOST_AD_W-1:0] host_ad_in,
    output logic                               host_wr_n,
    output logic                               host_rd_n,
    output logic                               host_latch,
    output logic                               host_sel_n,
    input  wire logic                          host_ack,
    input  wire logic                          host_ready
);
    import rspm_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int SYNC_W = NUM_PF + SP_PINS + ADDR_W + DATA_W;

    logic [SYNC_W-1:0]   sync_meta;
    logic [SYNC_W-1:0]   sync_out;
    logic [NUM_PF-1:0]   pf_sync;
    logic [SP_PINS-1:0]  sp_sync;
    logic [ADDR_W-1:0]   addr_sync;
    logic [DATA_W-1:0]   data_sync;

    // Data path flops carry no reset so straps can be seen during reset
    always_ff @(posedge clk) begin
        sync_meta <= {pf_pin_in, sp1_pin_in, addr_pin_in, data_pin_in};
        sync_out  <= sync_meta;
    end

    assign {pf_sync, sp_sync, addr_sync, data_sync} = sync_out;

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    logic [NUM_STRAP-1:0] strap;

    always_ff @(posedge clk) begin
        if (srst) begin
            strap <= pf_sync[NUM_STRAP-1:0]; // R3
        end
    end
    // Strap held outside reset, so later pin traffic cannot alter it // R4

    assign strap_value = strap;
    assign host_mode   = strap[STRAP_C]; // R6

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0]    ctrl;
    logic [NUM_PF-1:0]    flag_dir;
    logic [NUM_PF-1:0]    flag_out;
    logic [NUM_SRC-1:0]   int_status;
    logic [NUM_SRC-1:0]   int_mask;
    logic [NUM_OFLAG-1:0] oflags;
    logic                 wr_en;
    logic [NUM_SRC-1:0]   int_set;
    logic [NUM_SRC-1:0]   w1c;

    function automatic logic is_mapped(input logic [APB_AW-1:0] a);
        case (a)
            ADDR_CTRL, ADDR_FLAG_DIR, ADDR_FLAG_OUT, ADDR_FLAG_IN,
            ADDR_INT_STAT, ADDR_INT_MASK, ADDR_STRAP, ADDR_OUT_FLAGS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);

    // Serial port roles may change at any time; no reset gating here // R1
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= CTRL_RST;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            ctrl <= pwdata[CTRL_W-1:0]; // R11
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flag_dir <= PF_RST;
        end else if (wr_en && paddr == ADDR_FLAG_DIR) begin
            flag_dir <= pwdata[NUM_PF-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flag_out <= PF_RST;
        end else if (wr_en && paddr == ADDR_FLAG_OUT) begin
            flag_out <= pwdata[NUM_PF-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            int_mask <= SRC_RST;
        end else if (wr_en && paddr == ADDR_INT_MASK) begin
            int_mask <= pwdata[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            oflags <= OFLAG_RST;
        end else if (wr_en && paddr == ADDR_OUT_FLAGS) begin
            oflags <= pwdata[NUM_OFLAG-1:0];
        end
    end

    assign output_only_flags = oflags;

    // ------------------------------------------------------------------
    // Interrupt detection
    // ------------------------------------------------------------------
    // Sources are active low; the pin level is read back through the pad,
    // so a flag driven low by this device interrupts just like a board one.
    logic [NUM_SRC-1:0] src_level;
    logic [NUM_SRC-1:0] src_prev;
    logic [NUM_SRC-1:0] src_fall;
    logic [NUM_SRC-1:0] src_edge_mode;
    logic               alt_en;

    assign alt_en = ctrl[CTRL_ALT_EN];

    always_comb begin
        src_level              = '0;
        src_level[SRC_EDGE]    = !pf_sync[PF_EDGE];   // R2
        src_level[SRC_LEVEL0]  = !pf_sync[PF_LEVEL0]; // R2
        src_level[SRC_LEVEL1]  = !pf_sync[PF_LEVEL1]; // R2
        src_level[SRC_CFG]     = !pf_sync[PF_CFG];    // R2
        src_level[SRC_ALT0]    = alt_en && !sp_sync[SP_ALT_INT0]; // R11
        src_level[SRC_ALT1]    = alt_en && !sp_sync[SP_ALT_INT1]; // R11
    end

    always_comb begin
        src_edge_mode             = '0;
        src_edge_mode[SRC_EDGE]   = 1'b1;                  // R10
        src_edge_mode[SRC_LEVEL0] = 1'b0;                  // R10
        src_edge_mode[SRC_LEVEL1] = 1'b0;                  // R10
        src_edge_mode[SRC_CFG]    = ctrl[CTRL_CFG_EDGE];   // R10
        src_edge_mode[SRC_ALT0]   = ctrl[CTRL_ALT0_EDGE];
        src_edge_mode[SRC_ALT1]   = ctrl[CTRL_ALT1_EDGE];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            src_prev <= SRC_RST;
        end else begin
            src_prev <= src_level;
        end
    end

    assign src_fall = src_level & ~src_prev;
    assign int_set  = (src_edge_mode & src_fall) | (~src_edge_mode & src_level); // R10
    assign w1c      = (wr_en && paddr == ADDR_INT_STAT) ? pwdata[NUM_SRC-1:0] : SRC_RST;

    // A new event in the clearing cycle survives: set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            int_status <= SRC_RST;
        end else begin
            int_status <= (int_status & ~w1c) | int_set;
        end
    end

    assign int_pending = int_status & int_mask; // R5
    assign irq         = |int_pending;          // R5

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    always_comb begin
        prdata = '0;
        if (psel) begin
            case (paddr)
                ADDR_CTRL:      prdata[CTRL_W-1:0]    = ctrl;
                ADDR_FLAG_DIR:  prdata[NUM_PF-1:0]    = flag_dir;
                ADDR_FLAG_OUT:  prdata[NUM_PF-1:0]    = flag_out;
                ADDR_FLAG_IN:   prdata[NUM_PF:0]      = {serial_alt_flag_in, pf_sync};
                ADDR_INT_STAT:  prdata[NUM_SRC-1:0]   = int_status;
                ADDR_INT_MASK:  prdata[NUM_SRC-1:0]   = int_mask;
                ADDR_STRAP:     prdata[NUM_STRAP-1:0] = strap;
                ADDR_OUT_FLAGS: prdata[NUM_OFLAG-1:0] = oflags;
                default:        prdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Flag pins
    // ------------------------------------------------------------------
    // Straps need the pins undriven, so drivers stay off throughout reset
    assign pf_pin_out = flag_out;
    assign pf_pin_oe  = flag_dir & ~{NUM_PF{srst}}; // R3

    // ------------------------------------------------------------------
    // Second serial port pins
    // ------------------------------------------------------------------
    always_comb begin
        sp1_pin_out = sp1_core_out;
        sp1_pin_oe  = sp1_core_oe;
        sp1_core_in = sp_sync;
        if (alt_en) begin
            sp1_pin_oe[SP_ALT_INT0]  = 1'b0;                 // R11
            sp1_pin_oe[SP_ALT_INT1]  = 1'b0;                 // R11
            sp1_pin_oe[SP_ALT_FI]    = 1'b0;                 // R11
            sp1_pin_out[SP_ALT_FO]   = ctrl[CTRL_ALT_FLAG];  // R11
            sp1_pin_oe[SP_ALT_FO]    = 1'b1;                 // R11
            sp1_core_in[SP_ALT_FO:0] = '1;
        end
    end

    assign serial_alt_flag_in = alt_en && sp_sync[SP_ALT_FI];

    // ------------------------------------------------------------------
    // External bus pins
    // ------------------------------------------------------------------
    logic ack_pull;

    // Mode D strap: low acks on transfer done, high on ready to accept
    assign ack_pull = strap[STRAP_D] ? host_ready : host_ack; // R12

    always_comb begin
        addr_pin_out = mem_addr;                 // R8
        addr_pin_oe  = '1;                       // R8
        data_pin_out = mem_wdata;                // R9
        data_pin_oe  = {DATA_W{mem_data_oe}};    // R9
        mem_rdata    = data_sync;
        host_ad_in   = '0;                       // R7
        host_wr_n    = 1'b1;                     // R7
        host_rd_n    = 1'b1;                     // R7
        host_latch   = 1'b0;                     // R7
        host_sel_n   = 1'b1;                     // R7
        if (srst) begin
            addr_pin_oe = '0;                    // R1
            data_pin_oe = '0;                    // R1
        end else if (host_mode) begin
            addr_pin_out[ADDR_W-1:1] = host_ad_out[HOST_LO_W-1:0]; // R7
            addr_pin_oe[ADDR_W-1:1]  = {HOST_LO_W{host_ad_oe}};   // R7
            data_pin_out[HOST_HI_W-1:0] = host_ad_out[HOST_AD_W-1:HOST_LO_W];
            data_pin_oe[HOST_HI_W-1:0]  = {HOST_HI_W{host_ad_oe}};
            data_pin_oe[D_WR:D_CTL_LO]  = '0;
            data_pin_out[D_ACK] = 1'b0;                            // R12
            data_pin_oe[D_ACK]  = ack_pull;                        // R12
            mem_rdata[D_WIDE_LO-1:0] = '0;                         // R7
            host_ad_in = {data_sync[HOST_HI_W-1:0], addr_sync[ADDR_W-1:1]};
            host_wr_n  = data_sync[D_WR];
            host_rd_n  = data_sync[D_RD];
            host_latch = data_sync[D_LATCH];
            host_sel_n = data_sync[D_SEL];
        end else if (mem_byte_access) begin
            data_pin_out[DATA_W-1:DATA_W-BYTE_HI_W] = mem_byte_addr_hi; // R9
            data_pin_oe[DATA_W-1:DATA_W-BYTE_HI_W]  = '1;               // R9
        end
    end

endmodule : rspm_pin_mux

`default_nettype wire

// file: rspm_pkg.sv
// Constants shared by the pin-function multiplexer and its register file
package rspm_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam int        APB_AW        = 8;
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_FLAG_DIR = 8'h04;
    localparam logic [7:0] ADDR_FLAG_OUT = 8'h08;
    localparam logic [7:0] ADDR_FLAG_IN = 8'h0c;
    localparam logic [7:0] ADDR_INT_STAT = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK = 8'h14;
    localparam logic [7:0] ADDR_STRAP   = 8'h18;
    localparam logic [7:0] ADDR_OUT_FLAGS = 8'h1c;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_W          = 5;
    localparam int CTRL_ALT_EN     = 0;
    localparam int CTRL_CFG_EDGE   = 1;
    localparam int CTRL_ALT0_EDGE  = 2;
    localparam int CTRL_ALT1_EDGE  = 3;
    localparam int CTRL_ALT_FLAG   = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

    // ------------------------------------------------------------------
    // Flags, straps and interrupt sources
    // ------------------------------------------------------------------
    localparam int NUM_PF      = 8;
    localparam int NUM_STRAP   = 4;
    localparam int NUM_OFLAG   = 3;
    localparam int STRAP_C     = 2;
    localparam int STRAP_D     = 3;
    localparam int PF_EDGE     = 4;
    localparam int PF_LEVEL0   = 5;
    localparam int PF_LEVEL1   = 6;
    localparam int PF_CFG      = 7;
    localparam int NUM_SRC     = 6;
    localparam int SRC_EDGE    = 0;
    localparam int SRC_LEVEL0  = 1;
    localparam int SRC_LEVEL1  = 2;
    localparam int SRC_CFG     = 3;
    localparam int SRC_ALT0    = 4;
    localparam int SRC_ALT1    = 5;
    localparam logic [NUM_PF-1:0]   PF_RST   = 8'h00;
    localparam logic [NUM_SRC-1:0]  SRC_RST  = 6'h00;
    localparam logic [NUM_OFLAG-1:0] OFLAG_RST = 3'h0;

    // ------------------------------------------------------------------
    // Second serial port pins
    // ------------------------------------------------------------------
    localparam int SP_PINS     = 5;
    localparam int SP_ALT_INT0 = 0;
    localparam int SP_ALT_INT1 = 1;
    localparam int SP_ALT_FI   = 2;
    localparam int SP_ALT_FO   = 3;

    // ------------------------------------------------------------------
    // External bus widths and host-mode pin positions
    // ------------------------------------------------------------------
    localparam int ADDR_W      = 14;
    localparam int DATA_W      = 24;
    localparam int BYTE_HI_W   = 8;
    localparam int HOST_AD_W   = 16;
    localparam int HOST_LO_W   = 13;
    localparam int HOST_HI_W   = 3;
    localparam int D_WR        = 7;
    localparam int D_RD        = 6;
    localparam int D_LATCH     = 5;
    localparam int D_SEL       = 4;
    localparam int D_ACK       = 3;
    localparam int D_CTL_LO    = 3;
    localparam int D_WIDE_LO   = 8;

endpackage : rspm_pkg
